// File: test_two_mode_interrupt_controller.sv
`timescale 1ns/100ps
`default_nettype none
module test_two_mode_interrupt_controller;
  import tmic_pkg::*;
  logic clock, rst, hw_standby, nmi_pin, int_accept, trap_exec, int_req, pen;
  logic dtc_ack, dtc_req;
  logic [7:0] dtc_vector;
  logic [TMIC_NUM_INT-1:0] int_src;
  tmic_bus_s bus;
  logic [7:0] rdata, ext_n, key_n, int_vector;
  tmic_cpu_s cpu;
  tmic_exc_s exc;
  logic [1:0] trap_num;
  logic [15:0] mem_addr, mem_addr_eff;
  tmic_size_e mem_size;
  logic [3:0] plat;
  logic [23:0] hist;
  int bad_count, n_compared;
  localparam logic [15:0] RA [6] = '{ADDR_SYSCTL, ADDR_KEY_MASK,
    ADDR_ENABLE, ADDR_FLAGS, ADDR_PRIO_A, 16'hfe00};
  localparam logic [7:0] RV [6] = '{RST_SYSCTL, RST_ZERO, RST_ZERO,
    RST_ZERO, RST_ZERO, RST_ZERO};

  tmic_top dut_u (.clock, .rst, .hw_standby, .bus, .rdata, .nmi_pin,
    .external_request_lines_n(ext_n), .key_inputs_n(key_n),
    .internal_req(int_src), .cpu, .int_accept, .trap_exec, .trap_num,
    .int_req, .int_vector, .dtc_ack, .dtc_req, .dtc_vector, .exc,
    .mem_addr, .mem_size, .mem_addr_eff);
  tmic_cpu_model cpu_u (.clock, .rst, .en(pen), .lat(plat), .int_req,
    .int_vector, .int_accept, .hist);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
    @(posedge clock);
  endtask : rd

  task automatic tr(input int n, input logic [7:0] e);
    trap_num <= 2'(n);
    trap_exec <= 1'b1;
    @(posedge clock);
    trap_exec <= 1'b0;
    #1;
    chk("trap_vec", VEC_TRAP_BASE + 8'(n), exc.vector);
    chk("trap_ccr", e, {5'h00, exc.strobe, exc.ccr_i, exc.ccr_ui});
    @(posedge clock);
  endtask : tr

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  initial begin
    #500_000;
    bad_count++;
    end_sim();
  end

  initial begin
    bus = '0;
    rst = 1'b1;
    hw_standby = 1'b0;
    nmi_pin = 1'b1;
    ext_n = 8'hff;
    key_n = 8'hff;
    cpu = '{1'b1, 1'b0, 1'b0, 3'h5, 1'b1};
    trap_exec = 1'b0;
    trap_num = 2'h0;
    mem_addr = 16'h0000;
    mem_size = TMIC_BYTE;
    pen = 1'b0;
    plat = 4'h2;
    dtc_ack = 1'b0;
    int_src = '0;
    bad_count = 0;
    n_compared = 0;
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    foreach (RA[i]) rd(RA[i], RV[i]);
    wr(ADDR_SYSCTL, 8'h17);
    rd(ADDR_SYSCTL, 8'h1f);
    rd(ADDR_KEY_MASK, RST_KEY_MASK);
    hw_standby <= 1'b1;
    cyc(2);
    hw_standby <= 1'b0;
    cyc(1);
    rd(ADDR_SYSCTL, RST_SYSCTL);
    $display("registers done");
    cpu.ccr_i <= 1'b1;
    wr(ADDR_ENABLE, 8'hff);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_SENSE_LO, 8'(c << 2));
      ext_n[1] <= 1'b0;
      cyc(5);
      chk("int_req", 8'h00, {7'h00, int_req});
      rd(ADDR_FLAGS, (c == 2) ? 8'h00 : 8'h02);
      wr(ADDR_FLAGS, 8'hff);
      rd(ADDR_FLAGS, (c == 2) ? 8'h00 : 8'h02);
      wr(ADDR_FLAGS, 8'h00);
      ext_n[1] <= 1'b1;
      cyc(5);
      rd(ADDR_FLAGS, (c == 1) ? 8'h00 : 8'h02);
      wr(ADDR_FLAGS, 8'h00);
      rd(ADDR_FLAGS, 8'h00);
    end
    $display("sense done");
    wr(ADDR_SYSCTL, 8'h02);
    wr(ADDR_KEY_MASK, 8'hfe);
    rd(ADDR_KEY_MASK, 8'hfe);
    wr(ADDR_SENSE_HI, 8'h10);
    key_n[1] <= 1'b0;
    cyc(5);
    rd(ADDR_FLAGS, 8'h00);
    key_n <= 8'hfe;
    cyc(5);
    rd(ADDR_FLAGS, 8'h40);
    key_n <= 8'hff;
    wr(ADDR_FLAGS, 8'h00);
    $display("keys done");
    wr(ADDR_SYSCTL, 8'h17);
    nmi_pin <= 1'b0;
    wr(ADDR_SENSE_LO, 8'h01);
    wr(ADDR_SENSE_HI, 8'h01);
    ext_n <= 8'hee;
    cyc(5);
    chk("int_req", 8'h00, {7'h00, int_req});
    wr(ADDR_PRIO_A, 8'h10);
    cyc(2);
    chk("int_vector", 8'h14, int_req ? int_vector : 8'hff);
    cpu.ccr_ui <= 1'b1;
    cyc(2);
    chk("int_req", 8'h00, {7'h00, int_req});
    nmi_pin <= 1'b1;
    cyc(5);
    chk("int_vector", VEC_NMI, int_req ? int_vector : 8'hff);
    cpu.ccr_i <= 1'b0;
    cpu.ccr_ui <= 1'b0;
    pen <= 1'b1;
    cyc(30);
    chk("first", VEC_NMI, hist[23:16]);
    chk("second", 8'h14, hist[15:8]);
    chk("third", 8'h10, hist[7:0]);
    chk("int_req", 8'h00, {7'h00, int_req});
    pen <= 1'b0;
    $display("priority done");
    wr(ADDR_DTC_ROUTE, 8'h04);
    wr(ADDR_SENSE_LO, 8'h11);
    ext_n[2] <= 1'b0;
    cyc(5);
    chk("dtc_req", 8'h01, {7'h00, dtc_req});
    chk("dtc_vector", VEC_EXT_BASE + 8'h02, dtc_vector);
    chk("int_req", 8'h00, {7'h00, int_req});
    dtc_ack <= 1'b1;
    @(posedge clock);
    dtc_ack <= 1'b0;
    @(posedge clock);
    chk("dtc_req", 8'h00, {7'h00, dtc_req});
    rd(ADDR_FLAGS, 8'h00);
    int_src <= 14'h0011;
    cyc(3);
    chk("int_vector", 8'h18, int_req ? int_vector : 8'hff);
    wr(ADDR_PRIO_B, 8'h40);
    cyc(2);
    chk("int_vector", 8'h1c, int_req ? int_vector : 8'hff);
    int_src <= '0;
    $display("routing done");
    for (int n = 0; n < 4; n++) tr(n, 8'h07);
    wr(ADDR_SYSCTL, 8'h02);
    tr(3, 8'h06);
    $display("trap done");
    for (int s = 0; s < 3; s++) begin
      mem_addr <= 16'h1235;
      mem_size <= tmic_size_e'(s);
      @(posedge clock);
      #1;
      chk("mem_addr", (s == 0) ? 8'h35 : 8'h34, mem_addr_eff[7:0]);
      @(posedge clock);
    end
    mem_addr <= 16'h1236;
    mem_size <= TMIC_WORD;
    @(posedge clock);
    #1;
    chk("stack_addr", 8'h36, mem_addr_eff[7:0]);
    $display("align done");
    end_sim();
  end
endmodule : test_two_mode_interrupt_controller
`default_nettype wire

// File: tmic_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module tmic_cpu_model
  import tmic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic en,
  input wire logic [3:0] lat,
  input wire logic int_req,
  input wire logic [7:0] int_vector,
  output logic int_accept,
  output logic [23:0] hist
);
  logic [3:0] wait_reg;
  // takes a vector after lat cycles, records the order taken
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      int_accept <= 1'b0;
      wait_reg <= 4'h0;
      hist <= '0;
    end else begin
      int_accept <= 1'b0;
      if (!en || !int_req || int_accept) begin
        wait_reg <= 4'h0;
      end else if (wait_reg < lat) begin
        wait_reg <= wait_reg + 4'h1;
      end else begin
        int_accept <= 1'b1;
        hist <= {hist[15:0], int_vector};
        wait_reg <= 4'h0;
      end
    end
  end
endmodule : tmic_cpu_model
`default_nettype wire

// File: tmic_pkg.sv
// Contract
// - nonmaskable request highest, never masked
// - edge select bit picks falling or rising
// - mode field selects mode 0 or 1
// - system control loads 09, survives software standby
// - per-module priority bits for maskable sources
// - each source gives its own vector
// - external requests sense edge, edges or level
// - key inputs share sixth request line
// - key inputs active low, falling or level
// - requests may start the transfer controller
// - trap taken whenever executing, ignoring masks; code drops it if an interrupt is accepted in the same cycle
// - trap number 0 to 3 picks vector
// - trap sets I, UI in mode 1
// - word accesses force lowest address bit zero
// - flags clear only by written zero; code also clears on accept, transfer ack and hardware standby
// - sense code 00 low 01 fall 10 rise 11 both
// - priority bit set means level 1
`default_nettype none
package tmic_pkg;
  localparam int TMIC_ADDR_W = 16;
  localparam int TMIC_DATA_W = 8;
  localparam int TMIC_NUM_EXT = 8;
  localparam int TMIC_NUM_INT = 14;
  localparam int TMIC_NUM_SRC = 22;
  localparam int TMIC_SHARED_LINE = 6;

  localparam logic [15:0] ADDR_PRIO_A = 16'hfee8;
  localparam logic [15:0] ADDR_PRIO_B = 16'hfee9;
  localparam logic [15:0] ADDR_PRIO_C = 16'hfeea;
  localparam logic [15:0] ADDR_FLAGS = 16'hfeeb;
  localparam logic [15:0] ADDR_SENSE_HI = 16'hfeec;
  localparam logic [15:0] ADDR_SENSE_LO = 16'hfeed;
  localparam logic [15:0] ADDR_BRK_CTL = 16'hfef4;
  localparam logic [15:0] ADDR_BRK_A = 16'hfef5;
  localparam logic [15:0] ADDR_BRK_B = 16'hfef6;
  localparam logic [15:0] ADDR_BRK_C = 16'hfef7;
  localparam logic [15:0] ADDR_ENABLE = 16'hffc2;
  localparam logic [15:0] ADDR_SYSCTL = 16'hffc4;
  localparam logic [15:0] ADDR_KEY_MASK = 16'hfff1;
  localparam logic [15:0] ADDR_DTC_ROUTE = 16'hfee0;

  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SYSCTL = 8'h09;
  localparam logic [7:0] RST_KEY_MASK = 8'hbf;
  localparam logic [7:0] SYSCTL_WR_MASK = 8'hd7;

  localparam int SYS_MODE_HI_BIT = 5;
  localparam int SYS_MODE_LO_BIT = 4;
  localparam int SYS_NMI_EDGE_BIT = 2;
  localparam int SYS_HOST_IF_BIT = 1;

  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;

  localparam logic [7:0] VEC_NMI = 8'h07;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h08;
  localparam logic [7:0] VEC_EXT_BASE = 8'h10;

  // bit of {prio_a, prio_b, prio_c} that sets each source's level
  localparam int unsigned ICR_MAP [TMIC_NUM_SRC] = '{
    23, 22, 21, 21, 20, 20, 19, 19, 18, 17, 16,
    15, 14, 11, 10, 9, 8, 7, 6, 5, 4, 3};

  typedef enum logic [1:0] {TMIC_BYTE, TMIC_WORD, TMIC_LONG} tmic_size_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmic_bus_s;

  typedef struct packed {
    logic running;
    logic ccr_i;
    logic ccr_ui;
    logic [2:0] exr_level;
    logic exr_trace;
  } tmic_cpu_s;

  typedef struct packed {
    logic strobe;
    logic [7:0] vector;
    logic ccr_i;
    logic ccr_ui;
    logic [2:0] exr_level;
    logic exr_trace;
  } tmic_exc_s;
endpackage : tmic_pkg
`default_nettype wire

// File: tmic_top.sv
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module tmic_top
  import tmic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hw_standby,
  input wire tmic_bus_s bus,
  output logic [7:0] rdata,
  input wire logic nmi_pin,
  input wire logic [7:0] external_request_lines_n,
  input wire logic [7:0] key_inputs_n,
  input wire logic [TMIC_NUM_INT-1:0] internal_req,
  input wire tmic_cpu_s cpu,
  input wire logic int_accept,
  input wire logic trap_exec,
  input wire logic [1:0] trap_num,
  output logic int_req,
  output logic [7:0] int_vector,
  input wire logic dtc_ack,
  output logic dtc_req,
  output logic [7:0] dtc_vector,
  output tmic_exc_s exc,
  input wire logic [15:0] mem_addr,
  input wire tmic_size_e mem_size,
  output logic [15:0] mem_addr_eff
);
  logic [7:0] prio_a_reg, prio_b_reg, prio_c_reg;
  logic [7:0] flags_reg, seen_reg;
  logic [7:0] sense_hi_reg, sense_lo_reg;
  logic [7:0] brk_ctl_reg, brk_a_reg, brk_b_reg, brk_c_reg;
  logic [7:0] enable_reg, sysctl_reg, key_mask_reg, dtc_route_reg;
  logic [7:0] rdata_reg;
  logic nmi_meta_reg, nmi_sync_reg, nmi_prev_reg, nmi_pend_reg;
  logic [7:0] ext_meta_reg, ext_sync_reg, key_meta_reg, key_sync_reg;
  logic [7:0] line_prev_reg;
  logic int_req_reg, sel_nmi_reg, sel_lvl_reg;
  logic [4:0] sel_idx_reg;
  logic [7:0] int_vector_reg;
  logic dtc_req_reg;
  logic [2:0] dtc_idx_reg;
  logic [7:0] dtc_vector_reg;
  tmic_exc_s exc_reg;
  logic [15:0] mem_addr_reg;

  logic wr_hit, mode1, key_low, nmi_edge;
  logic [7:0] line_n, sw_clr, acc_clr, dtc_clr, clr_mask;
  logic [15:0] sense_all;
  logic [23:0] icr_all;
  wire [7:0] ext_set;
  wire [7:0] clr_ok;

  assign wr_hit = bus.wr;
  assign mode1 = sysctl_reg[SYS_MODE_LO_BIT];
  assign sense_all = {sense_hi_reg, sense_lo_reg};
  assign icr_all = {prio_a_reg, prio_b_reg, prio_c_reg};

  // two-flop synchronisers for the nonmaskable, request and key pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nmi_meta_reg <= 1'b1;
      nmi_sync_reg <= 1'b1;
      ext_meta_reg <= '1;
      ext_sync_reg <= '1;
      key_meta_reg <= '1;
      key_sync_reg <= '1;
    end else begin
      nmi_meta_reg <= nmi_pin;
      nmi_sync_reg <= nmi_meta_reg;
      ext_meta_reg <= external_request_lines_n;
      ext_sync_reg <= ext_meta_reg;
      key_meta_reg <= key_inputs_n;
      key_sync_reg <= key_meta_reg;
    end
  end

  // any unmasked key held low pulls the shared line low
  assign key_low = |(~key_sync_reg & ~key_mask_reg);

  always_comb begin
    line_n = ext_sync_reg;
    line_n[TMIC_SHARED_LINE] = ext_sync_reg[TMIC_SHARED_LINE]
      & ~key_low;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_prev_reg <= '1;
      nmi_prev_reg <= 1'b1;
    end else begin
      line_prev_reg <= line_n;
      nmi_prev_reg <= nmi_sync_reg;
    end
  end

  // per-line sense decode
  genvar g;
  generate
    for (g = 0; g < TMIC_NUM_EXT; g++) begin : g_sense
      logic [1:0] code;
      assign code = sense_all[2*g+1:2*g];
      assign ext_set[g] =
        (code == SENSE_LOW) ? ~line_n[g] :
        (code == SENSE_FALL) ? (line_prev_reg[g] & ~line_n[g]) :
        (code == SENSE_RISE) ? (~line_prev_reg[g] & line_n[g]) :
        (line_prev_reg[g] ^ line_n[g]);
      assign clr_ok[g] = (code != SENSE_LOW) | line_n[g];
    end
  endgenerate

  // nonmaskable edge capture
  assign nmi_edge = sysctl_reg[SYS_NMI_EDGE_BIT] ?
    (~nmi_prev_reg & nmi_sync_reg) : (nmi_prev_reg & ~nmi_sync_reg);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nmi_pend_reg <= 1'b0;
    end else begin
      nmi_pend_reg <= (nmi_pend_reg & ~(int_accept & sel_nmi_reg))
        | nmi_edge;
    end
  end

  // flag clear sources
  always_comb begin
    sw_clr = '0;
    acc_clr = '0;
    dtc_clr = '0;
    if (wr_hit && bus.addr == ADDR_FLAGS) begin
      sw_clr = ~bus.wdata & seen_reg;
    end
    if (int_accept && !sel_nmi_reg && sel_idx_reg < 5'(TMIC_NUM_EXT)) begin
      acc_clr[sel_idx_reg[2:0]] = clr_ok[sel_idx_reg[2:0]];
    end
    if (dtc_ack && dtc_req_reg) begin
      dtc_clr[dtc_idx_reg] = clr_ok[dtc_idx_reg];
    end
    clr_mask = sw_clr | acc_clr | dtc_clr;
  end

  // set wins over clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_reg <= RST_ZERO;
      seen_reg <= RST_ZERO;
    end else if (hw_standby) begin
      flags_reg <= RST_ZERO;
      seen_reg <= RST_ZERO;
    end else begin
      flags_reg <= (flags_reg & ~clr_mask) | ext_set;
      if (bus.rd && bus.addr == ADDR_FLAGS) begin
        seen_reg <= flags_reg;
      end else begin
        seen_reg <= seen_reg & ~clr_mask;
      end
    end
  end

  // writable registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prio_a_reg <= RST_ZERO;
      prio_b_reg <= RST_ZERO;
      prio_c_reg <= RST_ZERO;
      sense_hi_reg <= RST_ZERO;
      sense_lo_reg <= RST_ZERO;
      brk_ctl_reg <= RST_ZERO;
      brk_a_reg <= RST_ZERO;
      brk_b_reg <= RST_ZERO;
      brk_c_reg <= RST_ZERO;
      enable_reg <= RST_ZERO;
      sysctl_reg <= RST_SYSCTL;
      key_mask_reg <= RST_KEY_MASK;
      dtc_route_reg <= RST_ZERO;
    end else if (hw_standby) begin
      prio_a_reg <= RST_ZERO;
      prio_b_reg <= RST_ZERO;
      prio_c_reg <= RST_ZERO;
      sense_hi_reg <= RST_ZERO;
      sense_lo_reg <= RST_ZERO;
      brk_ctl_reg <= RST_ZERO;
      brk_a_reg <= RST_ZERO;
      brk_b_reg <= RST_ZERO;
      brk_c_reg <= RST_ZERO;
      enable_reg <= RST_ZERO;
      sysctl_reg <= RST_SYSCTL;
      key_mask_reg <= RST_KEY_MASK;
      dtc_route_reg <= RST_ZERO;
    end else if (wr_hit) begin
      case (bus.addr)
        ADDR_PRIO_A: prio_a_reg <= bus.wdata;
        ADDR_PRIO_B: prio_b_reg <= bus.wdata;
        ADDR_PRIO_C: prio_c_reg <= bus.wdata;
        ADDR_SENSE_HI: sense_hi_reg <= bus.wdata;
        ADDR_SENSE_LO: sense_lo_reg <= bus.wdata;
        ADDR_BRK_CTL: brk_ctl_reg <= bus.wdata;
        ADDR_BRK_A: brk_a_reg <= bus.wdata;
        ADDR_BRK_B: brk_b_reg <= bus.wdata;
        ADDR_BRK_C: brk_c_reg <= bus.wdata;
        ADDR_ENABLE: enable_reg <= bus.wdata;
        ADDR_DTC_ROUTE: dtc_route_reg <= bus.wdata;
        ADDR_SYSCTL: begin
          // upper mode bit and fixed bit are read-only
          sysctl_reg <= (bus.wdata & SYSCTL_WR_MASK)
            | (sysctl_reg & ~SYSCTL_WR_MASK);
        end
        ADDR_KEY_MASK: begin
          if (sysctl_reg[SYS_HOST_IF_BIT]) begin
            key_mask_reg <= bus.wdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= RST_ZERO;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_PRIO_A: rdata_reg <= prio_a_reg;
        ADDR_PRIO_B: rdata_reg <= prio_b_reg;
        ADDR_PRIO_C: rdata_reg <= prio_c_reg;
        ADDR_FLAGS: rdata_reg <= flags_reg;
        ADDR_SENSE_HI: rdata_reg <= sense_hi_reg;
        ADDR_SENSE_LO: rdata_reg <= sense_lo_reg;
        ADDR_BRK_CTL: rdata_reg <= brk_ctl_reg;
        ADDR_BRK_A: rdata_reg <= brk_a_reg;
        ADDR_BRK_B: rdata_reg <= brk_b_reg;
        ADDR_BRK_C: rdata_reg <= brk_c_reg;
        ADDR_ENABLE: rdata_reg <= enable_reg;
        ADDR_SYSCTL: rdata_reg <= sysctl_reg;
        ADDR_DTC_ROUTE: rdata_reg <= dtc_route_reg;
        ADDR_KEY_MASK: begin
          rdata_reg <= sysctl_reg[SYS_HOST_IF_BIT] ? key_mask_reg : RST_ZERO;
        end
        default: rdata_reg <= RST_ZERO;
      endcase
    end else begin
      rdata_reg <= RST_ZERO;
    end
  end

  // pick the request to present to the cpu
  logic pick_any, pick_lvl, pick_hi;
  logic [4:0] pick_idx;
  always_comb begin
    logic req, lvl, ok;
    req = 1'b0;
    lvl = 1'b0;
    ok = 1'b0;
    pick_any = 1'b0;
    pick_lvl = 1'b0;
    pick_hi = 1'b0;
    pick_idx = '0;
    for (int i = 0; i < TMIC_NUM_SRC; i++) begin
      if (i < TMIC_NUM_EXT) begin
        req = flags_reg[i] & enable_reg[i] & ~dtc_route_reg[i];
      end else begin
        req = internal_req[i-TMIC_NUM_EXT];
      end
      lvl = icr_all[ICR_MAP[i]];
      if (!mode1) begin
        ok = ~cpu.ccr_i;
      end else begin
        ok = ~cpu.ccr_i | (~cpu.ccr_ui & lvl);
      end
      if (req && ok && lvl && !pick_hi) begin
        pick_hi = 1'b1;
        pick_any = 1'b1;
        pick_lvl = 1'b1;
        pick_idx = 5'(i);
      end else if (req && ok && !pick_any) begin
        pick_any = 1'b1;
        pick_idx = 5'(i);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      int_req_reg <= 1'b0;
      sel_nmi_reg <= 1'b0;
      sel_lvl_reg <= 1'b0;
      sel_idx_reg <= '0;
      int_vector_reg <= RST_ZERO;
    end else if (int_accept) begin
      int_req_reg <= 1'b0;
      sel_nmi_reg <= 1'b0;
    end else if (nmi_pend_reg) begin
      int_req_reg <= 1'b1;
      sel_nmi_reg <= 1'b1;
      sel_lvl_reg <= 1'b1;
      int_vector_reg <= VEC_NMI;
    end else begin
      int_req_reg <= pick_any;
      sel_nmi_reg <= 1'b0;
      sel_lvl_reg <= pick_lvl;
      sel_idx_reg <= pick_idx;
      int_vector_reg <= VEC_EXT_BASE + 8'(pick_idx);
    end
  end

  // transfer controller path for routed external requests
  logic [7:0] dtc_cand;
  logic dtc_any;
  logic [2:0] dtc_pick;
  always_comb begin
    dtc_cand = flags_reg & enable_reg & dtc_route_reg;
    dtc_any = 1'b0;
    dtc_pick = '0;
    for (int i = 0; i < TMIC_NUM_EXT; i++) begin
      if (dtc_cand[i] && !dtc_any) begin
        dtc_any = 1'b1;
        dtc_pick = 3'(i);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dtc_req_reg <= 1'b0;
      dtc_idx_reg <= '0;
      dtc_vector_reg <= RST_ZERO;
    end else if (dtc_ack) begin
      dtc_req_reg <= 1'b0;
    end else begin
      dtc_req_reg <= dtc_any;
      dtc_idx_reg <= dtc_pick;
      dtc_vector_reg <= VEC_EXT_BASE + 8'(dtc_pick);
    end
  end

  // mask-bit update after accepted interrupt or trap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exc_reg <= '0;
    end else begin
      exc_reg.exr_level <= cpu.exr_level;
      exc_reg.exr_trace <= cpu.exr_trace;
      exc_reg.ccr_i <= 1'b1;
      if (int_accept && int_req_reg) begin
        exc_reg.strobe <= 1'b1;
        exc_reg.vector <= int_vector_reg;
        exc_reg.ccr_ui <= (mode1 & sel_lvl_reg) | cpu.ccr_ui;
      end else if (trap_exec && cpu.running) begin
        exc_reg.strobe <= 1'b1;
        exc_reg.vector <= VEC_TRAP_BASE + {6'h00, trap_num};
        exc_reg.ccr_ui <= mode1 | cpu.ccr_ui;
      end else begin
        exc_reg.strobe <= 1'b0;
        exc_reg.vector <= RST_ZERO;
        exc_reg.ccr_ui <= cpu.ccr_ui;
      end
    end
  end

  // word and longword accesses ignore the lowest address bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_addr_reg <= '0;
    end else if (mem_size == TMIC_BYTE) begin
      mem_addr_reg <= mem_addr;
    end else begin
      mem_addr_reg <= {mem_addr[15:1], 1'b0};
    end
  end

  assign rdata = rdata_reg;
  assign int_req = int_req_reg;
  assign int_vector = int_vector_reg;
  assign dtc_req = dtc_req_reg;
  assign dtc_vector = dtc_vector_reg;
  assign exc = exc_reg;
  assign mem_addr_eff = mem_addr_reg;
endmodule : tmic_top
`default_nettype wire

// File: tmic_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tmic_top_monitor
  import tmic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic int_req,
  input wire logic [7:0] int_vector,
  input wire logic int_accept,
  input wire logic trap_exec,
  input wire logic [1:0] trap_num,
  input wire tmic_cpu_s cpu,
  input wire tmic_exc_s exc,
  input wire logic [15:0] mem_addr,
  input wire tmic_size_e mem_size,
  input wire logic [15:0] mem_addr_eff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_trap_vector: assert property (
    trap_exec && cpu.running && !int_accept
    |=> exc.strobe && exc.vector == {6'h02, $past(trap_num)})
    else $error("trap vector wrong");
  a_trap_ccr: assert property (
    trap_exec && cpu.running && !int_accept |=> exc.ccr_i
    && exc.exr_level == $past(cpu.exr_level)
    && exc.exr_trace == $past(cpu.exr_trace))
    else $error("trap status wrong");
  a_strobe_cause: assert property (
    exc.strobe |-> $past(int_accept && int_req || trap_exec && cpu.running))
    else $error("strobe without cause");
  a_accept_vector: assert property (
    int_accept && int_req |=> exc.strobe && exc.vector == $past(int_vector))
    else $error("accepted vector lost");
  a_accept_drop: assert property (
    int_accept && int_req |=> !int_req)
    else $error("request held after accept");
  a_vector_range: assert property (
    int_req |-> int_vector == VEC_NMI || int_vector inside {[8'h10:8'h25]})
    else $error("vector out of range");
  a_word_align: assert property (
    mem_size != TMIC_BYTE |=> mem_addr_eff == ($past(mem_addr) & 16'hfffe))
    else $error("word address not even");
  a_byte_pass: assert property (
    mem_size == TMIC_BYTE |=> mem_addr_eff == $past(mem_addr))
    else $error("byte address changed");
endmodule : tmic_top_monitor

bind tmic_top tmic_top_monitor mon_u (.clock, .rst, .int_req, .int_vector,
  .int_accept, .trap_exec, .trap_num, .cpu, .exc, .mem_addr, .mem_size,
  .mem_addr_eff);
`default_nettype wire
